// ==== hdl/intr_pkg.sv ====
package intr_pkg;
   localparam int NUM_SRC      = 20;
   localparam int LVL_W        = 4;
   localparam int TRAP_W       = 7;
   localparam int ADDR_W       = 24;
   localparam int PEC_CH       = 8;
   localparam int PEC_CH_W     = 3;
   localparam int NUM_EXT      = 8;
   localparam int VEC_SHIFT    = 2;
   localparam int PEC_MIN_LVL  = 14;
   localparam int PEC_PAGE_LIM = 24'h00FFFF;
   localparam logic [TRAP_W-1:0] NMI_TRAP_NUM = 7'h02;
   localparam logic [TRAP_W-1:0] HW_TRAP_NUM  = 7'h0A;

   typedef enum logic [1:0] {PUSH_IP, PUSH_PSW, PUSH_CSP} push_sel_t;

   typedef struct packed {
      logic              req;
      logic              enable;
      logic [LVL_W-1:0]  level;
      logic              pec_route;
      logic [PEC_CH_W-1:0] pec_chan;
   } src_ctrl_t;

   typedef struct packed {
      logic [ADDR_W-1:0] src_addr;
      logic [ADDR_W-1:0] dst_addr;
      logic              byte_mode;
   } pec_chan_t;

   typedef struct packed {
      logic              valid;
      push_sel_t         sel;
   } push_t;
endpackage : intr_pkg

// ==== hdl/interrupt_trap_event_service.sv ====
`timescale 1ns/1ps
`default_nettype none
module interrupt_trap_event_service #(
   parameter int N_SRC = intr_pkg::NUM_SRC
) (
   input  wire logic                         core_clk,
   input  wire logic                         reset,
   input  wire logic [N_SRC-1:0]             periph_event,
   input  wire logic [intr_pkg::NUM_EXT-1:0] port_pin_in,
   input  wire logic [intr_pkg::NUM_EXT-1:0] port_alt_intr,
   input  wire logic                         nmi_in_n,
   input  wire logic                         hw_trap_event,
   input  wire logic                         sw_trap_exec,
   input  wire logic [intr_pkg::TRAP_W-1:0]  sw_trap_num,
   input  wire intr_pkg::src_ctrl_t [N_SRC-1:0] src_cfg,
   input  wire logic [intr_pkg::TRAP_W-1:0]  src_trap_num [N_SRC],
   input  wire intr_pkg::pec_chan_t [intr_pkg::PEC_CH-1:0] pec_cfg,
   input  wire logic [intr_pkg::LVL_W-1:0]   cpu_level,
   input  wire logic                         segmented,
   input  wire logic                         cpu_ready,
   output logic                              suspend,
   output logic                              branch_valid,
   output logic [intr_pkg::ADDR_W-1:0]       branch_target,
   output intr_pkg::push_t                   push,
   output logic                              pec_stall,
   output logic                              pec_move_valid,
   output intr_pkg::pec_chan_t               pec_move,
   output logic [intr_pkg::PEC_CH_W-1:0]     pec_move_chan,
   output logic [N_SRC-1:0]                  req_flag
);
   import intr_pkg::*;

   typedef enum {IDLE, SAVE_IP, SAVE_PSW, SAVE_CSP, BRANCH, PEC_MOVE} state_t;

   function automatic logic [ADDR_W-1:0] vec_addr(input logic [TRAP_W-1:0] num);
      vec_addr = {{(ADDR_W-TRAP_W-VEC_SHIFT){1'b0}}, num, 2'b00};
   endfunction : vec_addr

   ////////////////////////////////////////////////////////////////////////////
   // Request flags, with external sources taken from port alternate functions.

   logic [N_SRC-1:0] next_req_flag;
   logic [N_SRC-1:0] raw_event;
   logic [N_SRC-1:0] clear_req;
   logic [NUM_EXT-1:0] pin_prev;
   logic             nmi_prev_n;
   logic             nmi_edge;

   // External pins are the lowest sources; a pin only counts if its alternate function is on.
   assign raw_event = periph_event |
      {{(N_SRC-NUM_EXT){1'b0}}, port_pin_in & ~pin_prev & port_alt_intr};
   // A new event wins over the clear caused by acceptance in the same cycle.
   assign next_req_flag = (req_flag & ~clear_req) | raw_event;
   assign nmi_edge = nmi_prev_n & ~nmi_in_n;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         req_flag   <= '0;
         // Track the pins through reset, so that a pin already high is not taken as an edge.
         pin_prev   <= port_pin_in;
         nmi_prev_n <= 1'b1;
      end else begin
         req_flag   <= next_req_flag;
         pin_prev   <= port_pin_in;
         nmi_prev_n <= nmi_in_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration: highest level wins, lower index breaks ties.

   logic [LVL_W-1:0] win_level;
   logic [4:0]       win_idx;
   logic             win_found;
   logic             win_pec;

   always_comb begin
      win_level = '0;
      win_idx   = '0;
      win_found = 1'b0;
      for (int i = 0; i < N_SRC; i++) begin
         if (req_flag[i] && src_cfg[i].enable &&
             (!win_found || src_cfg[i].level > win_level)) begin
            win_level = src_cfg[i].level;
            win_idx   = 5'(i);
            win_found = 1'b1;
         end
      end
   end

   logic nmi_pend;
   logic hw_pend;
   logic sw_pend;
   logic [TRAP_W-1:0] sw_num_hold;
   logic accept_intr;
   logic trap_any;
   state_t state;
   state_t next_state;

   assign win_pec     = src_cfg[win_idx].pec_route &&
                        (int'(win_level) >= PEC_MIN_LVL);
   assign accept_intr = win_found && (win_level > cpu_level);
   assign trap_any    = hw_pend || nmi_pend || sw_pend;

   ////////////////////////////////////////////////////////////////////////////
   // Service sequencer.

   // Vector number of the service being entered; it must stand still until the branch.
   logic [TRAP_W-1:0] serv_num;

   always_comb begin
      next_state = state;
      case (state)
         IDLE: begin
            if (cpu_ready) begin
               if (trap_any) begin
                  next_state = SAVE_IP;
               end else if (accept_intr && win_pec) begin
                  next_state = PEC_MOVE;
               end else if (accept_intr) begin
                  next_state = SAVE_IP;
               end
            end
         end
         SAVE_IP:  next_state = SAVE_PSW;
         SAVE_PSW: next_state = segmented ? SAVE_CSP : BRANCH;
         SAVE_CSP: next_state = BRANCH;
         BRANCH:   next_state = IDLE;
         PEC_MOVE: next_state = IDLE;
         default:  next_state = IDLE;
      endcase
   end

   logic take;
   logic take_pec;
   assign take     = (state == IDLE) && cpu_ready && !trap_any && accept_intr;
   assign take_pec = take && win_pec;
   always_comb begin
      clear_req = '0;
      if (take) begin
         clear_req[win_idx] = 1'b1;
      end
   end

   logic [TRAP_W-1:0] next_serv_num;
   assign next_serv_num = hw_pend  ? HW_TRAP_NUM :
                          nmi_pend ? NMI_TRAP_NUM :
                          sw_pend  ? sw_num_hold : src_trap_num[win_idx];

   logic trap_take;
   assign trap_take = (state == IDLE) && cpu_ready && trap_any;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state       <= IDLE;
         serv_num    <= '0;
         nmi_pend    <= 1'b0;
         hw_pend     <= 1'b0;
         sw_pend     <= 1'b0;
         sw_num_hold <= '0;
      end else begin
         state <= next_state;
         if (trap_take || take) begin
            serv_num <= next_serv_num;
         end
         // Only the highest pending trap is retired; a new event re-arms its flag.
         hw_pend  <= hw_trap_event || (hw_pend && !trap_take);
         nmi_pend <= nmi_edge || (nmi_pend && !(trap_take && !hw_pend));
         sw_pend  <= sw_trap_exec ||
                     (sw_pend && !(trap_take && !hw_pend && !nmi_pend));
         if (sw_trap_exec) begin
            sw_num_hold <= sw_trap_num;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event controller channel move.

   pec_chan_t sel_chan;
   assign sel_chan = pec_cfg[src_cfg[win_idx].pec_chan];

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pec_move      <= '0;
         pec_move_chan <= '0;
      end else if (take_pec) begin
         pec_move.src_addr  <= sel_chan.src_addr & PEC_PAGE_LIM[ADDR_W-1:0];
         pec_move.dst_addr  <= sel_chan.dst_addr & PEC_PAGE_LIM[ADDR_W-1:0];
         pec_move.byte_mode <= sel_chan.byte_mode;
         pec_move_chan      <= src_cfg[win_idx].pec_chan;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CPU-facing outputs.

   assign pec_stall      = (state == PEC_MOVE);
   assign pec_move_valid = (state == PEC_MOVE);
   assign suspend        = (state != IDLE) && (state != PEC_MOVE);

   // The push word is built whole, so the output has one driver.
   logic      push_on;
   push_sel_t push_code;
   assign push_on        = (state == SAVE_IP) || (state == SAVE_PSW) || (state == SAVE_CSP);
   assign push_code      = (state == SAVE_PSW) ? PUSH_PSW :
                           (state == SAVE_CSP) ? PUSH_CSP : PUSH_IP;
   assign push           = '{valid: push_on, sel: push_code};
   assign branch_valid   = (state == BRANCH);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         branch_target <= '0;
      end else begin
         branch_target <= vec_addr(serv_num);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_pec_one_cycle: assert property (@(posedge core_clk) disable iff (reset)
      pec_stall |=> !pec_stall) else $error("event move stalled too long");
   a_pec_no_push: assert property (@(posedge core_clk) disable iff (reset)
      take_pec |=> pec_move_valid && !push.valid) else $error("event move pushed");
   a_pec_top_lvl: assert property (@(posedge core_clk) disable iff (reset)
      take_pec |-> win_level >= 4'hE) else $error("event move at low level");
   a_intr_push_seq: assert property (@(posedge core_clk) disable iff (reset)
      (take && !win_pec) |=> push.valid && push.sel == PUSH_IP ##1
      push.valid && push.sel == PUSH_PSW) else $error("bad push order");
   a_no_csp_flat: assert property (@(posedge core_clk) disable iff (reset)
      (state == SAVE_PSW && !segmented) |=> branch_valid) else $error("csp pushed");
   a_trap_saves: assert property (@(posedge core_clk) disable iff (reset)
      trap_take |=> push.valid ##1 push.valid) else $error("trap status not saved");
   a_trap_first: assert property (@(posedge core_clk) disable iff (reset)
      (trap_any && state == IDLE) |-> !take) else $error("interrupt beat trap");
   a_level_gate: assert property (@(posedge core_clk) disable iff (reset)
      take |-> win_level > cpu_level) else $error("taken at low level");
   a_vec_times4: assert property (@(posedge core_clk) disable iff (reset)
      branch_valid |-> branch_target == {15'h0000, serv_num, 2'b00})
      else $error("bad vector");
   a_flag_clear: assert property (@(posedge core_clk) disable iff (reset)
      (take && !raw_event[win_idx]) |=> !req_flag[$past(win_idx)])
      else $error("flag not cleared");

   // A flag must be seen set the cycle after its event, whatever the sequencer does.
   a_flag_set: assert property (@(posedge core_clk) disable iff (reset)
      (raw_event != '0) |=> ((req_flag & $past(raw_event)) == $past(raw_event)))
      else $error("flag not set");

   // Entry and branch checks.
   a_branch_once: assert property (@(posedge core_clk) disable iff (reset)
      branch_valid |=> !branch_valid) else $error("branch held too long");
   a_suspend_span: assert property (@(posedge core_clk) disable iff (reset)
      (take && !win_pec) |=> suspend) else $error("program not suspended");
   a_ready_gate: assert property (@(posedge core_clk) disable iff (reset)
      (state == IDLE && !cpu_ready) |=> state == IDLE) else $error("entered while busy");
   a_csp_when_seg: assert property (@(posedge core_clk) disable iff (reset)
      (state == SAVE_PSW && segmented) |=> push.valid && push.sel == PUSH_CSP)
      else $error("segment pointer not pushed");

   // Event controller checks.
   a_pec_no_susp: assert property (@(posedge core_clk) disable iff (reset)
      pec_move_valid |-> !suspend) else $error("event move suspended program");
   a_pec_page: assert property (@(posedge core_clk) disable iff (reset)
      pec_move_valid |-> (pec_move.src_addr[ADDR_W-1:16] == '0) &&
      (pec_move.dst_addr[ADDR_W-1:16] == '0)) else $error("event move off page");
   a_pec_chan: assert property (@(posedge core_clk) disable iff (reset)
      take_pec |=> pec_move_chan == $past(src_cfg[win_idx].pec_chan))
      else $error("wrong event channel");
   a_pec_shared: assert property (@(posedge core_clk) disable iff (reset)
      take_pec |-> accept_intr && !trap_any) else $error("event move skipped arbitration");

   // Trap checks.
   a_nmi_arms: assert property (@(posedge core_clk) disable iff (reset)
      nmi_edge |=> nmi_pend) else $error("non-maskable edge lost");
   a_hw_vector: assert property (@(posedge core_clk) disable iff (reset)
      (trap_take && hw_pend) |-> next_serv_num == HW_TRAP_NUM)
      else $error("hardware trap not first");
   a_hw_retire: assert property (@(posedge core_clk) disable iff (reset)
      (trap_take && hw_pend && !hw_trap_event) |=> !hw_pend)
      else $error("hardware trap not retired");
   a_sw_vector: assert property (@(posedge core_clk) disable iff (reset)
      (trap_take && sw_pend && !hw_pend && !nmi_pend) |-> next_serv_num == sw_num_hold)
      else $error("software trap vector wrong");
   a_sw_num_hold: assert property (@(posedge core_clk) disable iff (reset)
      sw_trap_exec |=> sw_num_hold == $past(sw_trap_num))
      else $error("software trap number lost");
endmodule : interrupt_trap_event_service
`default_nettype wire

// ==== verification/cpu_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic slow,
   input  wire logic branch_valid,
   input  wire logic pec_stall,
   output var  logic cpu_ready
);
   logic [1:0] busy;

   // A slow core spends a few cycles in its handler prologue before it can take more service,
   // so the service logic must hold pending requests rather than assume instant readiness.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         busy <= 2'h0;
      end else if ((branch_valid || pec_stall) && slow) begin
         busy <= 2'h3;
      end else if (busy != 2'h0) begin
         busy <= busy - 2'h1;
      end
   end

   assign cpu_ready = !reset && (busy == 2'h0);
endmodule : cpu_core_model
`default_nettype wire

// ==== verification/test_interrupt_trap_event_service.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_trap_event_service;
   import intr_pkg::*;
   logic core_clk, reset, nmi_in_n, hw_trap_event, sw_trap_exec, segmented, cpu_ready, slow;
   logic [NUM_SRC-1:0] periph_event, req_flag;
   logic [NUM_EXT-1:0] port_pin_in, port_alt_intr;
   logic [TRAP_W-1:0] sw_trap_num, swn;
   src_ctrl_t [NUM_SRC-1:0] src_cfg;
   logic [TRAP_W-1:0] src_trap_num [NUM_SRC];
   pec_chan_t [PEC_CH-1:0] pec_cfg;
   logic [LVL_W-1:0] cpu_level;
   logic suspend, branch_valid, pec_stall, pec_move_valid;
   logic [ADDR_W-1:0] branch_target;
   push_t push;
   pec_chan_t pec_move;
   logic [PEC_CH_W-1:0] pec_move_chan;
   logic [31:0] exp_q [$];
   int err_count = 0;
   int cmp_count = 0;
   int i;

   interrupt_trap_event_service dut (.core_clk(core_clk), .reset(reset),
      .periph_event(periph_event), .port_pin_in(port_pin_in), .port_alt_intr(port_alt_intr),
      .nmi_in_n(nmi_in_n), .hw_trap_event(hw_trap_event), .sw_trap_exec(sw_trap_exec),
      .sw_trap_num(sw_trap_num), .src_cfg(src_cfg), .src_trap_num(src_trap_num),
      .pec_cfg(pec_cfg), .cpu_level(cpu_level), .segmented(segmented), .cpu_ready(cpu_ready),
      .suspend(suspend), .branch_valid(branch_valid), .branch_target(branch_target),
      .push(push), .pec_stall(pec_stall), .pec_move_valid(pec_move_valid),
      .pec_move(pec_move), .pec_move_chan(pec_move_chan), .req_flag(req_flag));
   cpu_core_model core (.core_clk(core_clk), .reset(reset), .slow(slow),
      .branch_valid(branch_valid), .pec_stall(pec_stall), .cpu_ready(cpu_ready));

   always #5 core_clk = ~core_clk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic note(input logic [7:0] k, input logic [23:0] v);
      if (exp_q.size() == 0) check("unexpected event", {k, v}, 32'h0);
      else check("event", {k, v}, exp_q.pop_front());
   endtask : note

   ////////////////////////////////////////////////////////////////////////////
   // Outputs stand for one cycle; look at them once the edge's updates have landed.
   always @(posedge core_clk) begin
      #2;
      if (push.valid === 1'b1) note(8'h01, 24'(push.sel));
      if (branch_valid === 1'b1) note(8'h02, branch_target);
      if (push.valid === 1'b1 || branch_valid === 1'b1) begin
         check("suspend", {31'h0, suspend}, 32'h1);
      end
      if (pec_move_valid === 1'b1) begin
         check("suspend", {31'h0, suspend}, 32'h0);
         note(8'h03, {19'h0, pec_stall, pec_move.byte_mode, pec_move_chan});
         note(8'h04, pec_move.src_addr);
         note(8'h05, pec_move.dst_addr);
      end
   end

   task automatic serv(input logic [TRAP_W-1:0] n, input logic seg);
      exp_q.push_back(32'h0100_0000);
      exp_q.push_back(32'h0100_0001);
      if (seg) exp_q.push_back(32'h0100_0002);
      exp_q.push_back({8'h02, 24'(n) << VEC_SHIFT});
   endtask : serv

   task automatic pec_exp(input logic [2:0] c);
      exp_q.push_back({8'h03, 19'h0, 1'b1, pec_cfg[c].byte_mode, c});
      exp_q.push_back({8'h04, pec_cfg[c].src_addr & 24'(PEC_PAGE_LIM)});
      exp_q.push_back({8'h05, pec_cfg[c].dst_addr & 24'(PEC_PAGE_LIM)});
   endtask : pec_exp

   task automatic cfg(input int s, input logic [3:0] lv, input logic pr, input logic [2:0] ch);
      src_cfg[s] = '{req: 1'b0, enable: 1'b1, level: lv, pec_route: pr, pec_chan: ch};
   endtask : cfg

   task automatic fire(input logic [NUM_SRC-1:0] m);
      periph_event = m;
      @(negedge core_clk);
      periph_event = '0;
   endtask : fire

   task automatic drain;
      int k;
      for (k = 0; k < 60 && exp_q.size() != 0; k++) @(negedge core_clk);
      repeat (6) @(negedge core_clk);
   endtask : drain

   task automatic close_out;
      if (err_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   initial begin
      #100000;
      err_count++;
      close_out();
   end

   initial begin
      core_clk = 0; reset = 1; nmi_in_n = 1; hw_trap_event = 0; sw_trap_exec = 0;
      sw_trap_num = '0; segmented = 0; slow = 0; cpu_level = '0; periph_event = '0;
      port_pin_in = '0; port_alt_intr = '0; src_cfg = '0;
      void'($urandom(32'h3FCB));
      for (i = 0; i < NUM_SRC; i++) src_trap_num[i] = 7'($urandom);
      for (i = 0; i < PEC_CH; i++) pec_cfg[i] = {24'($urandom), 24'($urandom), 1'($urandom)};
      repeat (8) @(negedge core_clk);
      reset = 0;
      @(negedge core_clk);
      segmented = 1;
      cfg(3, 4'h5, 1'b0, 3'h0);
      serv(src_trap_num[3], 1'b1);
      fire(20'h0_0008);
      drain();
      segmented = 0;
      slow = 1;
      cfg(4, 4'h6, 1'b0, 3'h0);
      cfg(9, 4'h9, 1'b0, 3'h0);
      serv(src_trap_num[9], 1'b0);
      serv(src_trap_num[4], 1'b0);
      fire(20'h0_0210);
      drain();
      cfg(2, 4'h6, 1'b0, 3'h0);
      cfg(7, 4'h6, 1'b0, 3'h0);
      serv(src_trap_num[2], 1'b0);
      serv(src_trap_num[7], 1'b0);
      fire(20'h0_0084);
      drain();
      cfg(11, 4'h3, 1'b0, 3'h0);
      cpu_level = 4'h3;
      fire(20'h0_0800);
      drain();
      check("req_flag", {31'h0, req_flag[11]}, 32'h1);
      serv(src_trap_num[11], 1'b0);
      cpu_level = 4'h2;
      drain();
      cpu_level = 4'h0;
      for (i = 0; i < PEC_CH; i++) begin
         cfg(12, 4'hE | 4'(i & 1), 1'b1, 3'(i));
         pec_exp(3'(i));
         fire(20'h0_1000);
         drain();
      end
      cfg(12, 4'hD, 1'b1, 3'h5);
      serv(src_trap_num[12], 1'b0);
      fire(20'h0_1000);
      drain();
      swn = 7'($urandom);
      cfg(5, 4'hF, 1'b0, 3'h0);
      serv(HW_TRAP_NUM, 1'b0);
      serv(NMI_TRAP_NUM, 1'b0);
      serv(swn, 1'b0);
      serv(src_trap_num[5], 1'b0);
      hw_trap_event = 1; nmi_in_n = 0; sw_trap_exec = 1; sw_trap_num = swn;
      fire(20'h0_0020);
      hw_trap_event = 0; sw_trap_exec = 0;
      drain();
      nmi_in_n = 1;
      port_alt_intr = 8'h08;
      cfg(3, 4'h7, 1'b0, 3'h0);
      serv(src_trap_num[3], 1'b0);
      port_pin_in = 8'h48;
      drain();
      check("req_flag", {31'h0, req_flag[6]}, 32'h0);
      check("pending notes", 32'(exp_q.size()), 32'h0);
      close_out();
   end
endmodule : test_interrupt_trap_event_service
`default_nettype wire
